//--- lce_ladder_evaluator.v
// cyclic ladder diagram evaluator with coil functions on relays
// Functional notes
// - whole diagram is scanned again and again, only in RUN.
// - diagram store holds 256 rungs of contacts and one coil.
// - four contact fields precede the single coil field of a rung.
// - leftmost field is fed from the rail, flow starts at 1.
// - make contact gives 1 when operand is true, else 0.
// - any field may be make or break; break inverts the operand.
// - in RUN the rung result drives its coil per coil function.
// - coil functions: contactor, impulse, set, reset, negated, rise, fall.
// - contactor: relay equals the current rung result.
// - impulse: relay toggles on each 0 to 1 rung change.
// - several non-retentive coils on one relay: last rung wins.
// - set, reset and impulse may drive one relay from many rungs.
// - power loss or STOP clears all relays except retentive ones.
// - set latches relay to 1 until a reset coil is driven true.
// - set and reset both true: higher rung number decides.
// - negated contactor: relay is inverse of rung result.
// - edge coils give relay 1 for exactly one scan after the edge.
`timescale 1ns/100ps
`include "lce_defines.vh"

module lce_ladder_evaluator #(
  parameter RELAY_N = 64,
  parameter IN_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // mode pins, asynchronous to clk_i
  input wire run_i,
  input wire power_ok_i,
  // input terminals, asynchronous to clk_i
  input wire [IN_W-1:0] in_i,
  // diagram load port, same clock domain
  input wire prog_we_i,
  input wire [`LCE_RUNG_AW-1:0] prog_addr_i,
  input wire [`LCE_RW_W-1:0] prog_data_i,
  // per relay retention setting, same clock domain
  input wire [RELAY_N-1:0] retain_i,
  // relay states and scan status
  output reg [RELAY_N-1:0] relay_o,
  output reg running_o,
  output reg scan_done_o,
  output reg [`LCE_RUNG_AW-1:0] rung_o
);

  // sequencer state codes, binary encoded
  localparam [1:0] ST_IDLE = `LCE_ST_IDLE;
  localparam [1:0] ST_FETCH = `LCE_ST_FETCH;
  localparam [1:0] ST_EXEC = `LCE_ST_EXEC;
  localparam [1:0] ST_CLEAR = `LCE_ST_CLEAR;
  // relay index only as wide as the relay bank, so no select runs past it
  localparam RLY_AW = $clog2(RELAY_N);

  // two-flop synchronisers for the mode pins and input terminals
  reg run_m;
  reg run_s;
  reg pwr_m;
  reg pwr_s;
  reg [IN_W-1:0] in_m;
  reg [IN_W-1:0] in_s;

  // diagram store and per rung previous flow
  reg [`LCE_RW_W-1:0] prog_mem [0:`LCE_RUNGS-1];
  reg prev_mem [0:`LCE_RUNGS-1];
  reg [`LCE_RW_W-1:0] rd_word;
  reg rd_prev;

  // sequencer
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`LCE_RUNG_AW-1:0] rung;
  reg [IN_W-1:0] in_img;
  reg carry;
  reg [RELAY_N-1:0] next_relay;

  wire active;
  wire flow;
  wire coil_en;
  wire [2:0] coil_fn;
  wire [`LCE_RW_RLY_MSB-`LCE_RW_RLY_LSB:0] coil_idx;
  wire idx_ok;
  wire rise;
  wire fall;
  wire [RLY_AW-1:0] coil_sel;
  wire exec_step;
  wire scan_end;

  // synchronisers; the first stage feeds only the second
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_m <= 1'b0;
      run_s <= 1'b0;
      pwr_m <= 1'b0;
      pwr_s <= 1'b0;
      in_m <= {IN_W{1'b0}};
      in_s <= {IN_W{1'b0}};
    end else begin
      run_m <= run_i;
      run_s <= run_m;
      pwr_m <= power_ok_i;
      pwr_s <= pwr_m;
      in_m <= in_i;
      in_s <= in_m;
    end
  end

  // scanning needs both RUN and supply present
  assign active = run_s & pwr_s;

  // diagram store: loads only while stopped, so a scan never sees a torn rung
  always @(posedge clk_i) begin
    if (prog_we_i && state == ST_IDLE) begin
      prog_mem[prog_addr_i] <= prog_data_i;
    end
    rd_word <= prog_mem[rung];
  end

  // previous rung flow for edge coils; swept to 0 whenever the scan stops
  always @(posedge clk_i) begin
    if (state == ST_CLEAR) begin
      prev_mem[rung] <= 1'b0;
    end else if (exec_step) begin
      prev_mem[rung] <= flow;
    end
    rd_prev <= prev_mem[rung];
  end

  // power flow of the fetched rung against the live relay image
  lce_rung_eval #(
    .RELAY_N(RELAY_N),
    .IN_W(IN_W)
  ) u_eval (
    .rung_i(rd_word),
    .relay_i(relay_o),
    .inp_i(in_img),
    .carry_i(carry),
    .flow_o(flow)
  );

  // coil field of the fetched rung
  assign coil_en = rd_word[`LCE_RW_COIL];
  assign coil_fn = rd_word[`LCE_RW_FN_MSB:`LCE_RW_FN_LSB];
  assign coil_idx = rd_word[`LCE_RW_RLY_MSB:`LCE_RW_RLY_LSB];
  assign idx_ok = ({1'b0, coil_idx} < RELAY_N);
  // upper index bits are already vetted by idx_ok
  assign coil_sel = coil_idx[RLY_AW-1:0];
  assign rise = flow & ~rd_prev;
  assign fall = ~flow & rd_prev;

  // one rung executes per exec cycle; the last one closes the scan
  assign exec_step = (state == ST_EXEC);
  assign scan_end = exec_step && active && (rung == `LCE_LAST_RUNG);

  // coil function applied to the addressed relay
  always @* begin
    next_relay = relay_o;
    if (coil_en && idx_ok) begin
      case (coil_fn)
        `LCE_FN_CONTACTOR: begin
          next_relay[coil_sel] = flow;
        end
        `LCE_FN_IMPULSE: begin
          if (rise) begin
            next_relay[coil_sel] = ~relay_o[coil_sel];
          end
        end
        `LCE_FN_SET: begin
          if (flow) begin
            next_relay[coil_sel] = 1'b1;
          end
        end
        `LCE_FN_RESET: begin
          if (flow) begin
            next_relay[coil_sel] = 1'b0;
          end
        end
        `LCE_FN_NEGATED: begin
          next_relay[coil_sel] = ~flow;
        end
        `LCE_FN_RISE: begin
          next_relay[coil_sel] = rise;
        end
        `LCE_FN_FALL: begin
          next_relay[coil_sel] = fall;
        end
        default: begin
          next_relay = relay_o; // unused code leaves the relay alone
        end
      endcase
    end
  end

  // sequencer transitions
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (active) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        // a stop mid-scan abandons the rest of the scan
        if (!active) begin
          next_state = ST_CLEAR;
        end else begin
          next_state = ST_FETCH;
        end
      end
      ST_CLEAR: begin
        if (rung == `LCE_LAST_RUNG) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_CLEAR;
      end
    endcase
  end

  // sequencer registers; reset starts by sweeping the edge memory
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_CLEAR;
      rung <= {`LCE_RUNG_AW{1'b0}};
      in_img <= {IN_W{1'b0}};
      carry <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        ST_IDLE: begin
          // input image frozen per scan keeps one scan self-consistent
          rung <= {`LCE_RUNG_AW{1'b0}};
          in_img <= in_s;
          carry <= 1'b0;
        end
        ST_EXEC: begin
          carry <= flow;
          if (!active) begin
            rung <= {`LCE_RUNG_AW{1'b0}};
          end else if (scan_end) begin
            // next scan follows at once, with a fresh input image
            rung <= {`LCE_RUNG_AW{1'b0}};
            in_img <= in_s;
            carry <= 1'b0;
          end else begin
            rung <= rung + 8'h01;
          end
        end
        ST_CLEAR: begin
          rung <= rung + 8'h01; // wraps to 0 when the sweep ends
        end
        default: begin
          rung <= rung;
        end
      endcase
    end
  end

  // relay image: rung writes land before the next rung is evaluated,
  // so the later of two coils on one relay wins
  // a stop outranks any coil write of the same cycle
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      relay_o <= {RELAY_N{1'b0}};
    end else if (!active) begin
      relay_o <= relay_o & retain_i;
    end else if (exec_step) begin
      relay_o <= next_relay;
    end
  end

  // true in the two states that make up a scan
  function scan_state;
    input [1:0] st;
    begin
      scan_state = (st == ST_FETCH) || (st == ST_EXEC);
    end
  endfunction

  // status outputs
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      running_o <= 1'b0;
      scan_done_o <= 1'b0;
      rung_o <= {`LCE_RUNG_AW{1'b0}};
    end else begin
      running_o <= scan_state(next_state);
      scan_done_o <= scan_end;
      rung_o <= rung;
    end
  end

endmodule // lce_ladder_evaluator

//--- lce_defines.vh
// shared constants of the ladder coil evaluator
`ifndef LCE_DEFINES_VH
`define LCE_DEFINES_VH

// number of rungs in the diagram store
`define LCE_RUNGS 256
`define LCE_RUNG_AW 8
`define LCE_LAST_RUNG 8'hff

// contact field layout: {used, break, operand[7:0]}
`define LCE_CT_W 10
`define LCE_CT_OP_LSB 0
`define LCE_CT_OP_MSB 7
`define LCE_CT_NEG 8
`define LCE_CT_USED 9
`define LCE_CT_FIELDS 4

// operand code: bit 7 set selects a terminal input, clear selects a relay
`define LCE_OP_IN_BIT 7
`define LCE_OP_SPACE 128

// rung word layout: contacts 0..3 in [39:0], contact 0 at the rail
`define LCE_RW_W 53
`define LCE_RW_RLY_LSB 40
`define LCE_RW_RLY_MSB 47
`define LCE_RW_FN_LSB 48
`define LCE_RW_FN_MSB 50
`define LCE_RW_COIL 51
`define LCE_RW_JOIN 52

// coil function codes
`define LCE_FN_CONTACTOR 3'h0
`define LCE_FN_IMPULSE 3'h1
`define LCE_FN_SET 3'h2
`define LCE_FN_RESET 3'h3
`define LCE_FN_NEGATED 3'h4
`define LCE_FN_RISE 3'h5
`define LCE_FN_FALL 3'h6

// scan sequencer states
`define LCE_ST_IDLE 2'h0
`define LCE_ST_FETCH 2'h1
`define LCE_ST_EXEC 2'h2
`define LCE_ST_CLEAR 2'h3

`endif

//--- lce_rung_eval.v
// power flow of one rung: four contact fields fed from the rail
`timescale 1ns/100ps
`include "lce_defines.vh"

module lce_rung_eval #(
  parameter RELAY_N = 64,
  parameter IN_W = 16
) (
  // rung word and operand images
  input wire [`LCE_RW_W-1:0] rung_i,
  input wire [RELAY_N-1:0] relay_i,
  input wire [IN_W-1:0] inp_i,
  // path result of the previous rung, for joined rungs
  input wire carry_i,
  // resulting power flow
  output wire flow_o
);

  // operand spaces padded so any 7-bit index lands on a defined bit
  wire [`LCE_OP_SPACE-1:0] rly_x;
  wire [`LCE_OP_SPACE-1:0] inp_x;
  wire [`LCE_CT_FIELDS-1:0] pass;

  assign rly_x = {{(`LCE_OP_SPACE-RELAY_N){1'b0}}, relay_i};
  assign inp_x = {{(`LCE_OP_SPACE-IN_W){1'b0}}, inp_i};

  // operand lookup, used by every contact field
  function op_val;
    input [7:0] op;
    input [`LCE_OP_SPACE-1:0] rly;
    input [`LCE_OP_SPACE-1:0] inp;
    begin
      if (op[`LCE_OP_IN_BIT]) begin
        op_val = inp[op[6:0]];
      end else begin
        op_val = rly[op[6:0]];
      end
    end
  endfunction

  // each used field passes its operand, inverted for a break contact; an unused field passes 1
  genvar k;
  generate
    for (k = 0; k < `LCE_CT_FIELDS; k = k + 1) begin : g_ct
      wire [`LCE_CT_W-1:0] fld;
      wire val;
      assign fld = rung_i[k*`LCE_CT_W +: `LCE_CT_W];
      assign val = op_val(fld[`LCE_CT_OP_MSB:`LCE_CT_OP_LSB], rly_x, inp_x);
      // make passes operand, break passes its inverse
      assign pass[k] = fld[`LCE_CT_USED] ? (val ^ fld[`LCE_CT_NEG]) : 1'b1;
    end
  endgenerate

  // rail feeds field 0, series fields AND, joined rungs OR
  assign flow_o = (&pass) | (rung_i[`LCE_RW_JOIN] & carry_i);

endmodule // lce_rung_eval

//--- lce_ladder_evaluator_monitor.sv
// assertion checker on the ladder coil evaluator ports
`timescale 1ns/100ps
module lce_ladder_evaluator_monitor #(
  parameter RELAY_N = 64,
  parameter IN_W = 16
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // mode pins and retention
  input wire run_i,
  input wire power_ok_i,
  input wire [RELAY_N-1:0] retain_i,
  // watched outputs
  input wire [RELAY_N-1:0] relay_o,
  input wire running_o,
  input wire scan_done_o,
  input wire [7:0] rung_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // five cycles cover the two-flop sync plus the registered outputs
  sequence s_stop;
    (!run_i && $stable(retain_i)) [*5];
  endsequence
  sequence s_nopwr;
    (!power_ok_i && $stable(retain_i)) [*5];
  endsequence
  AST_DONE_PULSE: assert property (scan_done_o |=> !scan_done_o)
    else $error("scan end pulse too long");
  AST_DONE_RUNNING: assert property (scan_done_o |-> $past(running_o))
    else $error("scan end without a scan");
  AST_RUN_STARTS: assert property ((run_i && power_ok_i) [*8] |-> ##[0:300] running_o)
    else $error("no scan in run mode");
  AST_STOP_IDLE: assert property (s_stop |-> !running_o)
    else $error("scanning while stopped");
  AST_PWR_IDLE: assert property (s_nopwr |-> !running_o)
    else $error("scanning without power");
  AST_STOP_CLEAR: assert property (s_stop |-> (relay_o & ~retain_i) == {RELAY_N{1'b0}})
    else $error("plain relay kept in stop");
  AST_PWR_CLEAR: assert property (s_nopwr |-> (relay_o & ~retain_i) == {RELAY_N{1'b0}})
    else $error("plain relay kept on power loss");
  AST_STOP_HOLD: assert property (s_stop ##1 $stable(retain_i) |-> $stable(relay_o))
    else $error("retained relay moved in stop");
  AST_LAST_RUNG: assert property (scan_done_o |-> rung_o == 8'hff)
    else $error("scan ended before the last rung");
endmodule // lce_ladder_evaluator_monitor

//--- lce_ladder_evaluator_bench.sv
// self-checking bench of the ladder coil evaluator
`timescale 1ns/100ps
module lce_ladder_evaluator_bench;
  reg clk_i = 1'h0, rst_i = 1'h1, run_i = 1'h0, power_ok_i = 1'h1, prog_we_i = 1'h0;
  reg [15:0] in_i = 16'h0;
  reg [7:0] prog_addr_i = 8'h0;
  reg [52:0] prog_data_i = 53'h0;
  reg [63:0] retain_i = 64'hc;
  wire [63:0] relay_o;
  wire running_o, scan_done_o;
  wire [7:0] rung_o;
  integer num_errors = 0, compares = 0, cycles = 0, gap = 0;
  // reference: toggle, latch, flow history and expected relays
  reg t = 1'h0, s = 1'h0, p1 = 1'h0;
  reg [10:0] e = 11'h0;

  lce_ladder_evaluator #(.RELAY_N(64), .IN_W(16)) u_lce_ladder_evaluator (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run_i), .power_ok_i(power_ok_i), .in_i(in_i),
    .prog_we_i(prog_we_i), .prog_addr_i(prog_addr_i), .prog_data_i(prog_data_i),
    .retain_i(retain_i), .relay_o(relay_o), .running_o(running_o),
    .scan_done_o(scan_done_o), .rung_o(rung_o));

  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // hang guard, well above the planned run
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 24000) begin
      num_errors = num_errors + 1;
      give_verdict;
    end
  end

  task check(input string nm, input [63:0] seen, input [63:0] want);
    compares = compares + 1;
    if (seen !== want) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, want, seen);
    end
  endtask

  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // falling edge sampling, the registered pulse is settled there
  // gap counts the cycles since the previous pulse
  task wait_done;
    gap = 0;
    @(negedge clk_i);
    gap = gap + 1;
    while (scan_done_o !== 1'h1) begin
      @(negedge clk_i);
      gap = gap + 1;
    end
  endtask

  function [52:0] w(input j, input [2:0] fn, input [7:0] r, input [9:0] c0, input [9:0] c1);
    w = {j, 1'h1, fn, r, 20'h0, c1, c0};
  endfunction

  // 'h28x reads input x, 'h300 is a break contact on relay 0
  function [52:0] prog(input integer a);
    case (a)
      0: prog = w(1'h0, 3'h0, 8'h00, 10'h280, 10'h0);
      1: prog = w(1'h0, 3'h4, 8'h01, 10'h280, 10'h0);
      2: prog = w(1'h0, 3'h1, 8'h02, 10'h281, 10'h0);
      3: prog = w(1'h0, 3'h2, 8'h03, 10'h282, 10'h0);
      4: prog = w(1'h0, 3'h3, 8'h03, 10'h283, 10'h0);
      5: prog = w(1'h0, 3'h5, 8'h04, 10'h281, 10'h0);
      6: prog = w(1'h0, 3'h6, 8'h05, 10'h281, 10'h0);
      7: prog = w(1'h0, 3'h0, 8'h06, 10'h300, 10'h0);
      8: prog = w(1'h0, 3'h0, 8'h07, 10'h284, 10'h285);
      9: prog = w(1'h1, 3'h0, 8'h08, 10'h286, 10'h0);
      10: prog = w(1'h0, 3'h0, 8'h09, 10'h280, 10'h0);
      // plain coils sit on one rung, relay 9 alone takes the allowed second
      11: prog = w(1'h0, 3'h0, 8'h09, 10'h281, 10'h0);
      12: prog = {2'h1, 3'h0, 8'h0a, 10'h203, 10'h383, 10'h282, 10'h281};
      default: prog = 53'h0;
    endcase
  endfunction

  // whole store written while idle, empty rungs carry no coil
  task load_program;
    integer a;
    for (a = 0; a < 256; a = a + 1) begin
      prog_we_i = 1'h1;
      prog_addr_i = a[7:0];
      prog_data_i = prog(a);
      @(negedge clk_i);
    end
    prog_we_i = 1'h0;
  endtask

  // inputs change mid-scan, judged after the first scan imaging them
  task step(input [6:0] v);
    wait_done;
    in_i = {9'h0, v};
    wait_done;
    wait_done;
    check("scan cycles", {32'h0, gap}, 64'h200);
    check("last rung", {56'h0, rung_o}, 64'hff);
    if (v[1] & ~p1) t = ~t;
    if (v[2]) s = 1'h1;
    if (v[3]) s = 1'h0;
    e = {v[1] & v[2] & ~v[3] & s, v[1], (v[4] & v[5]) | v[6], v[4] & v[5],
         ~v[0], ~v[1] & p1, v[1] & ~p1, s, t,
         ~v[0], v[0]};
    p1 = v[1];
    check("relays", relay_o, {53'h0, e});
    check("latches", {62'h0, relay_o[3:2]}, {62'h0, s, t});
    check("flow", {59'h0, relay_o[10:6]}, {59'h0, e[10:6]});
  endtask

  // a rung write while scanning is dropped, so rung 0 still drives relay 0
  task test_refused;
    wait_done;
    prog_we_i = 1'h1;
    prog_addr_i = 8'h00;
    prog_data_i = 53'h0;
    @(negedge clk_i);
    prog_we_i = 1'h0;
    step(7'h01);
  endtask

  // every coil function over a run of input images
  task test_coils;
    step(7'h01);
    step(7'h03);
    step(7'h07);
    step(7'h0d);
    step(7'h31);
    step(7'h42);
    step(7'h06);
  endtask

  // stop keeps retentive relays only; restart starts edge history afresh
  task test_stop;
    wait_done;
    run_i = 1'h0;
    in_i = 16'h0;
    repeat (6) @(negedge clk_i);
    check("stop", relay_o, {53'h0, e} & retain_i);
    check("halted", {63'h0, running_o}, 64'h0);
    t = t & retain_i[2];
    s = s & retain_i[3];
    p1 = 1'h0;
    repeat (300) @(negedge clk_i);
    run_i = 1'h1;
    step(7'h02);
  endtask

  // power loss with no retention clears every relay
  task test_power_loss;
    wait_done;
    retain_i = 64'h0;
    power_ok_i = 1'h0;
    repeat (6) @(negedge clk_i);
    check("power loss", relay_o, 64'h0);
  endtask

  // reset, load, run, then the scenarios
  initial begin
    repeat (3) @(negedge clk_i);
    rst_i = 1'h0;
    check("reset", relay_o, 64'h0);
    repeat (260) @(negedge clk_i);
    load_program;
    run_i = 1'h1;
    test_coils;
    test_refused;
    test_stop;
    test_power_loss;
    give_verdict;
  end
endmodule // lce_ladder_evaluator_bench

bind lce_ladder_evaluator lce_ladder_evaluator_monitor #(.RELAY_N(RELAY_N), .IN_W(IN_W)) u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .run_i(run_i), .power_ok_i(power_ok_i), .retain_i(retain_i),
  .relay_o(relay_o), .running_o(running_o), .scan_done_o(scan_done_o), .rung_o(rung_o));
